// ---- hdl/pirq_bank.sv ----
// Peripheral interrupt priority bank with AXI4-Lite register access
// Contract
// - One priority bit per peripheral source, held across five priority registers.
// - Priority bits act only while the priority-levels-on control bit is set.
// - Bit value 1 selects high priority, 0 selects low priority.
// - Reset sets every implemented bit; implemented bits are read/write.
// - Unimplemented positions ignore writes and read as zero.
// - Register 1 bits 7..0: slave port, converter, serial1 rx/tx, sync serial, timers.
// - Register 2: osc fail, bus collision, voltage detect, timer3 overflow, timer3 gate.
// - Register 3 bits 5..1: serial2 rx/tx, charge timer, capcomp2, capcomp1.
// - Register 4: timer4, nvm write, comparators 2/1, capcomp 5/4/3.
// - Register 5 bits 7..2: invalid msg, wake, bus error, tx buffers 2/1/0.
// - Register 5 bit 1: rx buffer 1 in mode 0, all received messages otherwise.
// - Register 5 bit 0: rx buffer 0 mode 0, zero mode 1, fifo full mode 2.
// - Voltage detect priority sits at bit 2 of register 2.
`timescale 1ns/1ps
`default_nettype none
`include "pirq_regs.svh"

module pirq_bank (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire pirq_pkg::pirq_src_t src_in,
    output logic [39:0] prio_out,
    output logic high_req,
    output logic low_req
);
    import pirq_pkg::*;

    // ==========================================================
    // Storage
    logic [7:0] prio_r [`PIRQ_NUM_REGS];
    logic [7:0] ctrl_r;
    pirq_axi_addr_t aw_r;
    pirq_axi_wdata_t w_r;
    pirq_can_mode_t mode;
    logic levels_on;
    logic [7:0] impl_mask [`PIRQ_NUM_REGS];
    logic [39:0] prio_flat;
    logic [39:0] active;
    logic wr_fire;
    logic [7:0] wr_idx;
    logic wr_hit;
    logic [7:0] rd_val;
    logic rd_hit;

    assign impl_mask[0] = `PIRQ_MASK_PRIO1;
    assign impl_mask[1] = `PIRQ_MASK_PRIO2;
    assign impl_mask[2] = `PIRQ_MASK_PRIO3;
    assign impl_mask[3] = `PIRQ_MASK_PRIO4;
    assign impl_mask[4] = `PIRQ_MASK_PRIO5;
    assign levels_on = ctrl_r[`PIRQ_CTRL_LEVELS_ON];
    assign mode = pirq_can_mode_t'(ctrl_r[`PIRQ_CTRL_MODE_HI:`PIRQ_CTRL_MODE_LO]);

    // ==========================================================
    // Write channel: address and data taken in either order
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            aw_r <= '0;
            s_axi_awready <= 1'b0;
        end else if (clk_en) begin
            s_axi_awready <= !aw_r.valid && !s_axi_awready && s_axi_awvalid;
            if (s_axi_awready && s_axi_awvalid) begin
                aw_r <= '{addr: s_axi_awaddr, valid: 1'b1};
            end else if (wr_fire) begin
                aw_r.valid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            w_r <= '0;
            s_axi_wready <= 1'b0;
        end else if (clk_en) begin
            s_axi_wready <= !w_r.valid && !s_axi_wready && s_axi_wvalid;
            if (s_axi_wready && s_axi_wvalid) begin
                w_r <= '{data: s_axi_wdata, strb: s_axi_wstrb, valid: 1'b1};
            end else if (wr_fire) begin
                w_r.valid <= 1'b0;
            end
        end
    end

    assign wr_fire = aw_r.valid && w_r.valid && !s_axi_bvalid;
    assign wr_idx = {2'b00, aw_r.addr[7:2]};
    assign wr_hit = (aw_r.addr[1:0] == 2'b00) && (wr_idx <= 8'h05);

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PIRQ_RESP_OKAY;
        end else if (clk_en) begin
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `PIRQ_RESP_OKAY : `PIRQ_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Priority registers
    genvar gi;
    generate
        for (gi = 0; gi < `PIRQ_NUM_REGS; gi++) begin : g_prio
            always_ff @(posedge clock) begin
                if (!rst_b) begin
                    prio_r[gi] <= `PIRQ_RST_PRIO & impl_mask[gi];
                end else if (clk_en && wr_fire && wr_idx == 8'(gi) && w_r.strb[0]) begin
                    prio_r[gi] <= w_r.data[7:0] & impl_mask[gi];
                end
            end
            assign prio_flat[gi*8 +: 8] = prio_r[gi];
        end
    endgenerate

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            ctrl_r <= `PIRQ_RST_CTRL;
        end else if (clk_en && wr_fire && wr_idx == 8'h05 && w_r.strb[0]) begin
            ctrl_r <= {5'h00, w_r.data[2:0]};
        end
    end

    // ==========================================================
    // Read channel
    always_comb begin
        rd_val = 8'h00;
        rd_hit = (s_axi_araddr[1:0] == 2'b00);
        unique case (s_axi_araddr[7:2])
            6'h00, 6'h01, 6'h02, 6'h03: rd_val = prio_r[s_axi_araddr[4:2]];
            6'h04: begin
                rd_val = prio_r[4];
                if (mode == PIRQ_CAN_MODE1) begin
                    rd_val[0] = 1'b0;
                end
            end
            6'h05: rd_val = ctrl_r;
            6'h06: rd_val = {6'h00, high_req, low_req};
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `PIRQ_RESP_OKAY;
        end else if (clk_en) begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (s_axi_arready && s_axi_arvalid) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h00_0000, rd_val};
                s_axi_rresp <= rd_hit ? `PIRQ_RESP_OKAY : `PIRQ_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Request routing
    always_comb begin
        active = src_in.pend & src_in.enab;
        if (mode == PIRQ_CAN_MODE1) begin
            active[32] = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            high_req <= 1'b0;
            low_req <= 1'b0;
            prio_out <= {`PIRQ_MASK_PRIO5, `PIRQ_MASK_PRIO4, `PIRQ_MASK_PRIO3,
                `PIRQ_MASK_PRIO2, `PIRQ_MASK_PRIO1} & {5{`PIRQ_RST_PRIO}};
        end else if (clk_en) begin
            prio_out <= prio_flat;
            if (levels_on) begin
                high_req <= |(active & prio_flat);
                low_req <= |(active & ~prio_flat);
            end else begin
                high_req <= |active;
                low_req <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Checks
    // Storage and reset
    a_reset_prio: assert property (
        @(posedge clock) $rose(rst_b) |-> prio_out == 40'hff_f7_3e_8f_ff)
        else $error("priority bits not set after reset");

    a_unimpl_zero: assert property (
        @(posedge clock) disable iff (!rst_b)
        (prio_r[1] & 8'h70) == 8'h00 && (prio_r[2] & 8'hc1) == 8'h00 && !prio_r[3][3])
        else $error("unimplemented bit set");

    a_unimpl_out: assert property (
        @(posedge clock) disable iff (!rst_b)
        (prio_out & 40'h00_08_c1_70_00) == 40'h00_0000_0000)
        else $error("unimplemented bit on priority output");

    a_prio_write: assert property (
        @(posedge clock) disable iff (!rst_b)
        clk_en && wr_fire && wr_idx == 8'h01 && w_r.strb[0]
        |=> prio_r[1] == ($past(w_r.data[7:0]) & 8'h8f))
        else $error("register 2 write wrong");

    a_voltage_write: assert property (
        @(posedge clock) disable iff (!rst_b)
        clk_en && wr_fire && wr_idx == 8'h01 && w_r.strb[0]
        |=> prio_r[1][2] == $past(w_r.data[2]))
        else $error("voltage detect bit not written");

    a_ctrl_write: assert property (
        @(posedge clock) disable iff (!rst_b)
        clk_en && wr_fire && wr_idx == 8'h05 && w_r.strb[0]
        |=> ctrl_r == {5'h00, $past(w_r.data[2:0])})
        else $error("control write wrong");

    a_prio_mirror: assert property (
        @(posedge clock) disable iff (!rst_b)
        clk_en |=> prio_out == $past(prio_flat))
        else $error("priority output does not follow the registers");

    a_freeze_hold: assert property (
        @(posedge clock) disable iff (!rst_b)
        !clk_en |=> $stable(prio_out) && $stable(high_req) && $stable(low_req)
        && $stable(prio_flat))
        else $error("state moved while clock enable low");

    // Request routing
    a_high_route: assert property (
        @(posedge clock) disable iff (!rst_b)
        clk_en && levels_on && |(active & prio_flat) |=> high_req)
        else $error("high request missing");

    a_high_clear: assert property (
        @(posedge clock) disable iff (!rst_b)
        clk_en && levels_on && !(|(active & prio_flat)) |=> !high_req)
        else $error("high request without a high source");

    a_low_route: assert property (
        @(posedge clock) disable iff (!rst_b)
        clk_en && levels_on && |(active & ~prio_flat) |=> low_req)
        else $error("low request missing");

    a_low_clear: assert property (
        @(posedge clock) disable iff (!rst_b)
        clk_en && levels_on && !(|(active & ~prio_flat)) |=> !low_req)
        else $error("low request without a low source");

    a_levels_off: assert property (
        @(posedge clock) disable iff (!rst_b)
        clk_en && !levels_on |=> !low_req)
        else $error("low request while levels off");

    a_off_any_high: assert property (
        @(posedge clock) disable iff (!rst_b)
        clk_en && !levels_on && |active |=> high_req)
        else $error("request lost while levels off");

    a_off_none_high: assert property (
        @(posedge clock) disable iff (!rst_b)
        clk_en && !levels_on && !(|active) |=> !high_req)
        else $error("request without source while levels off");

    a_mode1_mask: assert property (
        @(posedge clock) disable iff (!rst_b)
        clk_en && mode == PIRQ_CAN_MODE1 && (src_in.pend & src_in.enab) == 40'h01_0000_0000
        |=> !high_req && !low_req)
        else $error("masked receive source raised a request");

    // Register bus
    a_mode1_rd: assert property (
        @(posedge clock) disable iff (!rst_b)
        clk_en && s_axi_arready && s_axi_arvalid && s_axi_araddr == 8'h10
        && mode == PIRQ_CAN_MODE1 |=> !s_axi_rdata[0])
        else $error("mode 1 bit 0 not zero");

    a_bresp_once: assert property (
        @(posedge clock) disable iff (!rst_b)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");

    a_rvalid_hold: assert property (
        @(posedge clock) disable iff (!rst_b)
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");

    a_wr_answer: assert property (
        @(posedge clock) disable iff (!rst_b)
        clk_en && wr_fire |=> s_axi_bvalid)
        else $error("write response missing");

    a_rd_answer: assert property (
        @(posedge clock) disable iff (!rst_b)
        clk_en && s_axi_arready && s_axi_arvalid |=> s_axi_rvalid)
        else $error("read response missing");

    a_rd_upper: assert property (
        @(posedge clock) disable iff (!rst_b)
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
        else $error("read data above bit 7 not zero");

    a_slverr_rd: assert property (
        @(posedge clock) disable iff (!rst_b)
        clk_en && s_axi_arready && s_axi_arvalid && s_axi_araddr[1:0] != 2'b00
        |=> s_axi_rresp == `PIRQ_RESP_SLVERR)
        else $error("misaligned read not refused");

    a_bus_freeze: assert property (
        @(posedge clock) disable iff (!rst_b)
        !clk_en |=> $stable(s_axi_bvalid) && $stable(s_axi_rvalid))
        else $error("bus response moved while clock enable low");

    c_write: cover property (@(posedge clock) wr_fire && wr_hit);
    c_read: cover property (@(posedge clock) s_axi_rvalid && s_axi_rready);
    c_high: cover property (@(posedge clock) high_req && levels_on);
    c_low: cover property (@(posedge clock) low_req);
    c_frozen: cover property (@(posedge clock) !clk_en && (high_req || low_req));
endmodule : pirq_bank
`default_nettype wire

// ---- hdl/pirq_pkg.sv ----
// Types shared by the peripheral priority bank
`default_nettype none
package pirq_pkg;
    typedef enum logic [1:0] {
        PIRQ_CAN_MODE0,
        PIRQ_CAN_MODE1,
        PIRQ_CAN_MODE2,
        PIRQ_CAN_MODE3
    } pirq_can_mode_t;

    typedef struct packed {
        logic [7:0] addr;
        logic valid;
    } pirq_axi_addr_t;

    typedef struct packed {
        logic [31:0] data;
        logic [3:0] strb;
        logic valid;
    } pirq_axi_wdata_t;

    typedef struct packed {
        logic [39:0] pend;
        logic [39:0] enab;
    } pirq_src_t;
endpackage : pirq_pkg
`default_nettype wire

// ---- hdl/pirq_regs.svh ----
// Register offsets, field masks and reset values of the peripheral priority bank
`ifndef PIRQ_REGS_SVH
`define PIRQ_REGS_SVH

`define PIRQ_OFF_PRIO1 8'h00
`define PIRQ_OFF_PRIO2 8'h04
`define PIRQ_OFF_PRIO3 8'h08
`define PIRQ_OFF_PRIO4 8'h0c
`define PIRQ_OFF_PRIO5 8'h10
`define PIRQ_OFF_CTRL 8'h14
`define PIRQ_OFF_STAT 8'h18

`define PIRQ_MASK_PRIO1 8'hff
`define PIRQ_MASK_PRIO2 8'h8f
`define PIRQ_MASK_PRIO3 8'h3e
`define PIRQ_MASK_PRIO4 8'hf7
`define PIRQ_MASK_PRIO5 8'hff
`define PIRQ_RST_PRIO 8'hff

`define PIRQ_CTRL_LEVELS_ON 0
`define PIRQ_CTRL_MODE_LO 1
`define PIRQ_CTRL_MODE_HI 2
`define PIRQ_RST_CTRL 8'h00

`define PIRQ_RESP_OKAY 2'b00
`define PIRQ_RESP_SLVERR 2'b10
`define PIRQ_NUM_REGS 5

`endif

// ---- test/pirq_bank_test.sv ----
// Self-checking bench for the peripheral priority bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end

module pirq_bank_test;
    import pirq_pkg::*;
    logic clock, rst_b, clk_en, awv, wv, bre, arv, rre, awr, wrd, bv, arr, rv, hr, lr;
    logic [7:0] aa, ra;
    logic [31:0] wd, rdat;
    logic [3:0] ws;
    logic [1:0] brsp, rrsp;
    logic [39:0] po, m;
    pirq_src_t src;
    int error_cnt, tests_run;

    pirq_bank i_pirq_bank (.clock(clock), .rst_b(rst_b), .clk_en(clk_en),
        .s_axi_awaddr(aa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(brsp),
        .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ra), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rrsp), .s_axi_rvalid(rv),
        .s_axi_rready(rre), .src_in(src), .prio_out(po), .high_req(hr), .low_req(lr));

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // Implemented bits of each priority register
    function automatic logic [7:0] msk(input int i);
        case (i)
            1: msk = 8'h8f;
            2: msk = 8'h3e;
            3: msk = 8'hf7;
            default: msk = 8'hff;
        endcase
    endfunction : msk

    // Ready toward the slave starts low at random, so held responses are exercised too
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        aa <= a;
        wd <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'($urandom);
        do begin
            @(posedge clock);
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
            if (bv === 1'b1 && bre !== 1'b1) bre <= 1'b1;
        end while (bv !== 1'b1 || bre !== 1'b1);
        `CHK("bresp", 2'b00, brsp)
    endtask : wr

    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        ra <= a;
        arv <= 1'b1;
        rre <= 1'($urandom);
        do begin
            @(posedge clock);
            if (arr) arv <= 1'b0;
            if (rv === 1'b1 && rre !== 1'b1) rre <= 1'b1;
        end while (rv !== 1'b1 || rre !== 1'b1);
        `CHK("rdata", e, rdat)
        `CHK("rresp", er, rrsp)
    endtask : chk_rd

    task automatic req(input logic eh, input logic el);
        repeat (3) @(posedge clock);
        `CHK("high_req", eh, hr)
        `CHK("low_req", el, lr)
    endtask : req

    task automatic end_sim;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_sim

    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        end_sim();
    end

    initial begin
        logic [7:0] v;
        logic p;
        {rst_b, awv, wv, bre, arv, rre, aa, ra, wd} = '0;
        clk_en = 1'b1; ws = 4'hf; src = '0; error_cnt = 0; tests_run = 0;
        v = 8'($urandom(32'hcf92f236));
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        // =====================
        // Reset values
        `CHK("prio_out", 40'hff_f7_3e_8f_ff, po)
        for (int i = 0; i < 5; i++) chk_rd(8'(4 * i), {24'h0, msk(i)}, 2'b00);
        $display("done: reset values");
        // =====================
        // Write and read back, corner zero then random
        for (int k = 0; k < 3; k++) begin
            for (int i = 0; i < 5; i++) begin
                v = (k == 0) ? 8'h00 : 8'($urandom);
                m[8 * i +: 8] = v & msk(i);
                wr(8'(4 * i), v);
                chk_rd(8'(4 * i), {24'h0, m[8 * i +: 8]}, 2'b00);
                `CHK("prio_out", m[8 * i +: 8], po[8 * i +: 8])
            end
        end
        chk_rd(8'h1c, 32'h0, 2'b10);
        chk_rd(8'h05, {24'h0, m[15:8]}, 2'b10);
        $display("done: register access");
        // =====================
        // Routing of every source with levels on, mode 0
        wr(8'h14, 8'h01);
        for (int n = 0; n < 40; n++) begin
            v = msk(n / 8);
            if (v[n % 8]) begin
                p = 1'($urandom);
                m[n] = p;
                wr(8'(4 * (n / 8)), m[8 * (n / 8) +: 8]);
                src.pend <= 40'($urandom) | (40'h1 << n);
                src.enab <= 40'h1 << n;
                req(p, !p);
            end
        end
        $display("done: source routing");
        // =====================
        // CAN modes on the receive bits
        src.pend <= 40'h01_0000_0000;
        src.enab <= 40'h01_0000_0000;
        wr(8'h14, 8'h03);
        req(1'b0, 1'b0);
        chk_rd(8'h10, {24'h0, m[39:33], 1'b0}, 2'b00);
        src.pend <= 40'h02_0000_0000;
        src.enab <= 40'h02_0000_0000;
        req(m[33], !m[33]);
        src.pend <= 40'h01_0000_0000;
        src.enab <= 40'h01_0000_0000;
        wr(8'h14, 8'h05);
        req(m[32], !m[32]);
        chk_rd(8'h10, {24'h0, m[39:32]}, 2'b00);
        $display("done: receive modes");
        // =====================
        // Levels off: priority bits have no effect
        wr(8'h14, 8'h00);
        src.pend <= 40'hff_ff_ff_ff_ff;
        src.enab <= 40'hff_ff_ff_ff_ff;
        req(1'b1, 1'b0);
        chk_rd(8'h18, 32'h2, 2'b00);
        src.enab <= 40'h0;
        req(1'b0, 1'b0);
        $display("done: levels off");
        // =====================
        // Clock enable low freezes the request outputs
        wr(8'h14, 8'h01);
        src.pend <= 40'h1;
        src.enab <= 40'h1;
        req(m[0], !m[0]);
        chk_rd(8'h18, {30'h0, m[0], !m[0]}, 2'b00);
        clk_en <= 1'b0;
        src.enab <= 40'h0;
        req(m[0], !m[0]);
        `CHK("prio_out", m, po)
        clk_en <= 1'b1;
        req(1'b0, 1'b0);
        $display("done: clock enable");
        // =====================
        // Reset in mid-run restores every implemented bit
        rst_b <= 1'b0;
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        `CHK("prio_out", 40'hff_f7_3e_8f_ff, po)
        chk_rd(8'h14, 32'h0, 2'b00);
        chk_rd(8'h10, 32'hff, 2'b00);
        $display("done: reset in mid-run");
        end_sim();
    end
endmodule : pirq_bank_test

`default_nettype wire
